// *** verilog/clk_synth_pkg.sv ***
// Shared constants for the clock synthesizer control bank
package clk_synth_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_INPUT_CONTROL  = 8'h00;
	localparam logic [7:0] IDX_LOOP_CONTROL   = 8'h01;
	localparam logic [7:0] IDX_FB_DIV_LOW     = 8'h02;
	localparam logic [7:0] IDX_FB_DIV_HIGH    = 8'h03;
	localparam logic [7:0] IDX_PHASE_OFFSET   = 8'h04;
	localparam logic [7:0] IDX_PHASE_RES      = 8'h05;
	localparam logic [7:0] IDX_SOFT_RESET     = 8'h08;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int IC_PUMP_SRC   = 0;
	localparam int IC_HOLD_POL   = 1;
	localparam int IC_REF_POL    = 2;
	localparam int IC_FB_POL     = 3;
	localparam int IC_FB_SEL     = 4;
	localparam int IC_FUNC_SEL   = 5;
	localparam int IC_LOCK_EN    = 6;
	localparam int IC_REF_EN     = 7;
	localparam int OFS_FILTER    = 7;
	localparam int SR_PLL        = 0;
	localparam int SR_PHASE      = 1;

	// ----------------------------------------------------------------
	// Write masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_LOOP_CONTROL  = 8'h37;
	localparam logic [7:0] MASK_FB_DIV_HIGH   = 8'h0f;
	localparam logic [7:0] MASK_PHASE_OFFSET  = 8'hbf;
	localparam logic [7:0] RST_INPUT_CONTROL  = 8'h41;
	localparam logic [7:0] RST_LOOP_CONTROL   = 8'h00;
	localparam logic [7:0] RST_FB_DIV_LOW     = 8'hff;
	localparam logic [3:0] RST_FB_DIV_HIGH    = 4'hf;
	localparam logic [7:0] RST_PHASE_OFFSET   = 8'h00;
	localparam logic [1:0] RST_PHASE_RES      = 2'h3;

	// ----------------------------------------------------------------
	// Serial bus and timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  BUS_WRITE_ADDR_LOW = 8'h4c;
	localparam logic [12:0] FB_EXTRA_CLOCKS    = 13'h0008;
	localparam logic [2:0]  FUNC_PULSE_CLOCKS  = 3'h4;
	localparam logic [1:0]  REARM_SYNC_EDGES   = 2'h2;

endpackage : clk_synth_pkg

// *** verilog/serial_bus_slave.sv ***
// Byte level two-wire serial bus slave
`timescale 1ns/1ps
module serial_bus_slave (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       addr_select,
	input  wire logic [7:0] rd_data,
	output logic            wr_stb,
	output logic            wr_first,
	output logic [7:0]      wr_data,
	output logic            rd_adv
);

	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ACK, S_WRITE, S_READ, S_RACK
	} bus_state_t;

	typedef struct packed {
		bus_state_t fsm;
		logic       scl_p;
		logic       sda_p;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic       rnw;
		logic       first;
		logic       drive;
		logic       stb;
		logic       adv;
	} slave_t;

	slave_t s_q;
	slave_t s_d;
	logic   scl_rise;
	logic   scl_fall;
	logic   start_c;
	logic   stop_c;

	assign scl_rise = scl & ~s_q.scl_p;
	assign scl_fall = ~scl & s_q.scl_p;
	assign start_c  = scl & s_q.scl_p & s_q.sda_p & ~sda_in;
	assign stop_c   = scl & s_q.scl_p & ~s_q.sda_p & sda_in;

	// ----------------------------------------------------------------
	// Bit engine
	// ----------------------------------------------------------------
	always_comb begin
		s_d       = s_q;
		s_d.scl_p = scl;
		s_d.sda_p = sda_in;
		s_d.stb   = 1'b0;
		s_d.adv   = 1'b0;
		if (start_c) begin
			s_d.fsm   = S_ADDR;
			s_d.cnt   = 4'h0;
			s_d.drive = 1'b0;
		end else if (stop_c) begin
			s_d.fsm   = S_IDLE;
			s_d.drive = 1'b0;
		end else begin
			case (s_q.fsm)
				S_ADDR, S_WRITE: begin
					if (scl_rise && s_q.cnt < 4'h8) begin
						s_d.sh  = {s_q.sh[6:0], sda_in};
						s_d.cnt = s_q.cnt + 4'h1;
					end else if (scl_fall && s_q.cnt == 4'h8) begin
						if (s_q.fsm == S_ADDR) begin
							// Address match on select pin [RQ19]
							if (s_q.sh[7:2] == clk_synth_pkg::BUS_WRITE_ADDR_LOW[7:2]
								&& s_q.sh[1] == addr_select) begin
								s_d.rnw   = s_q.sh[0];
								s_d.first = 1'b1;
								s_d.drive = 1'b1;
								s_d.fsm   = S_ACK;
							end else begin
								s_d.fsm = S_IDLE;
							end
						end else begin
							s_d.stb   = 1'b1;
							s_d.drive = 1'b1;
							s_d.fsm   = S_ACK;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						s_d.cnt = 4'h0;
						if (s_q.fsm == S_ACK && s_q.stb == 1'b0
							&& s_q.rnw) begin
							s_d.sh    = rd_data;
							s_d.drive = ~rd_data[7];
							s_d.fsm   = S_READ;
						end else begin
							s_d.drive = 1'b0;
							s_d.fsm   = S_WRITE;
						end
						if (!s_q.rnw && s_q.cnt == 4'h8 && s_q.fsm == S_ACK) begin
							s_d.first = s_q.first;
						end
					end
				end
				S_READ: begin
					if (scl_fall) begin
						s_d.cnt = s_q.cnt + 4'h1;
						s_d.sh  = {s_q.sh[6:0], 1'b0};
						if (s_q.cnt == 4'h7) begin
							s_d.drive = 1'b0;
							s_d.fsm   = S_RACK;
						end else begin
							s_d.drive = ~s_q.sh[6];
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						if (sda_in) begin
							s_d.fsm = S_IDLE;
						end else begin
							s_d.adv = 1'b1;
						end
					end else if (scl_fall) begin
						s_d.cnt   = 4'h0;
						s_d.sh    = rd_data;
						s_d.drive = ~rd_data[7];
						s_d.fsm   = S_READ;
					end
				end
				default: begin
					s_d.drive = 1'b0;
				end
			endcase
		end
		if (s_q.stb) begin
			s_d.first = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '{fsm: S_IDLE, scl_p: 1'b1, sda_p: 1'b1, cnt: 4'h0,
				sh: 8'h00, rnw: 1'b0, first: 1'b0, drive: 1'b0,
				stb: 1'b0, adv: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign sda_out  = 1'b0;
	assign sda_oe   = s_q.drive;
	assign wr_stb   = s_q.stb;
	assign wr_first = s_q.first;
	assign wr_data  = s_q.sh;
	assign rd_adv   = s_q.adv;

endmodule : serial_bus_slave

// *** verilog/clock_synth_control_registers.sv ***
// Control register bank and sync logic of the clock synthesizer
`timescale 1ns/1ps
// Function
// RQ1 - Bit0: pump always on, else hold pin
// RQ2 - Bit1: hold pin active level select
// RQ3 - Bit2: reference edge, rising or falling
// RQ4 - Bit3: external feedback edge select
// RQ5 - Bit4: internal divider or external feedback
// RQ6 - Bit5: function output source select
// RQ7 - Bit6: lock status onto shared output
// RQ8 - Bit7: reference onto shared output
// RQ9 - Pump current code, binary steps
// RQ10 - Oscillator post-divide code, two bits
// RQ11 - Twelve-bit divide split over two indices
// RQ12 - Clocks per period equal divide plus eight; above divide 4088 the counter wraps every 4096 clocks, no feedback edge
// RQ13 - Host keeps offset below element count
// RQ14 - Offset bit7 selects loop filter
// RQ15 - Resolution code selects element count
// RQ16 - Upper resolution bits read revision
// RQ17 - Loop and divide copied on PLL reset
// RQ18 - Resolution copied on phase reset
// RQ19 - Select pin picks bus address
// RQ20 - Recovered sync pulse four clocks wide
// RQ21 - Shared output carries reference or lock
// RQ22 - Pump off at once, on after two edges
// RQ23 - Reserved bits read zero
// RQ24 - First byte indexes, later bytes stored
module clock_synth_control_registers #(
	parameter logic [5:0] MASK_REVISION = 6'h00
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        scl,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        bus_address_select_pin,
	input  wire logic        sync_in,
	input  wire logic        pump_hold_pin,
	input  wire logic        external_feedback_pin,
	input  wire logic        pll_lock,
	output logic             pump_enable,
	output logic             ref_edge,
	output logic             feedback_edge,
	output logic             func_out,
	output logic             lock_ref_out,
	output logic [2:0]       pump_current_code,
	output logic [1:0]       oscillator_postdivide_code,
	output logic [11:0]      feedback_divide,
	output logic [5:0]       phase_delay_offset,
	output logic [1:0]       phase_delay_resolution,
	output logic             internal_filter_select
);

	typedef struct packed {
		logic [7:0]  index;
		logic [7:0]  in_ctl;
		logic [7:0]  loop_sh;
		logic [7:0]  loop_wk;
		logic [7:0]  fbl_sh;
		logic [7:0]  fbl_wk;
		logic [3:0]  fbh_sh;
		logic [3:0]  fbh_wk;
		logic [7:0]  ofs;
		logic [1:0]  res_sh;
		logic [1:0]  res_wk;
		logic        sync_p;
		logic        xfb_p;
		logic        armed;
		logic [1:0]  edges;
		logic [11:0] div_cnt;
		logic        func;
		logic        lockref;
		logic        ref_ev;
		logic        fb_ev;
	} bank_t;

	bank_t b_q;
	bank_t b_d;

	logic       wr_stb;
	logic       wr_first;
	logic [7:0] wr_data;
	logic       rd_adv;
	logic [7:0] rd_data;
	logic       hold_active;
	logic       pump_request;
	logic       ref_ev_c;
	logic       div_wrap;
	logic [12:0] period;

	// ----------------------------------------------------------------
	// Serial bus engine
	// ----------------------------------------------------------------
	serial_bus_slave u_bus (
		.clk         (clk),
		.rst         (rst),
		.scl         (scl),
		.sda_in      (sda_in),
		.sda_out     (sda_out),
		.sda_oe      (sda_oe),
		.addr_select (bus_address_select_pin),
		.rd_data     (rd_data),
		.wr_stb      (wr_stb),
		.wr_first    (wr_first),
		.wr_data     (wr_data),
		.rd_adv      (rd_adv)
	);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	always_comb begin
		case (b_q.index)
			clk_synth_pkg::IDX_INPUT_CONTROL: rd_data = b_q.in_ctl;
			clk_synth_pkg::IDX_LOOP_CONTROL:  rd_data = b_q.loop_sh;
			clk_synth_pkg::IDX_FB_DIV_LOW:    rd_data = b_q.fbl_sh;
			clk_synth_pkg::IDX_FB_DIV_HIGH:   rd_data = {4'h0, b_q.fbh_sh}; // [RQ23]
			clk_synth_pkg::IDX_PHASE_OFFSET:  rd_data = b_q.ofs;
			clk_synth_pkg::IDX_PHASE_RES:     rd_data = {MASK_REVISION, b_q.res_sh}; // [RQ16]
			default:                          rd_data = 8'h00; // [RQ23]
		endcase
	end

	// ----------------------------------------------------------------
	// Sync edges and pump gating
	// ----------------------------------------------------------------
	assign hold_active = pump_hold_pin
		^ b_q.in_ctl[clk_synth_pkg::IC_HOLD_POL]; // [RQ2]
	assign pump_request = b_q.in_ctl[clk_synth_pkg::IC_PUMP_SRC]
		| hold_active; // [RQ1]
	assign ref_ev_c = b_q.in_ctl[clk_synth_pkg::IC_REF_POL]
		? (b_q.sync_p & ~sync_in) : (~b_q.sync_p & sync_in); // [RQ3]
	assign period   = {1'b0, b_q.fbh_wk, b_q.fbl_wk}
		+ clk_synth_pkg::FB_EXTRA_CLOCKS; // [RQ12]
	assign div_wrap = {1'b0, b_q.div_cnt} == period - 13'h0001;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		b_d        = b_q;
		b_d.sync_p = sync_in;
		b_d.xfb_p  = external_feedback_pin;
		b_d.ref_ev = ref_ev_c;
		// Index then data bytes, auto increment [RQ24]
		if (wr_stb && wr_first) begin
			b_d.index = wr_data;
		end else if (wr_stb) begin
			b_d.index = b_q.index + 8'h01;
			case (b_q.index)
				clk_synth_pkg::IDX_INPUT_CONTROL: b_d.in_ctl = wr_data;
				clk_synth_pkg::IDX_LOOP_CONTROL:
					b_d.loop_sh = wr_data & clk_synth_pkg::MASK_LOOP_CONTROL; // [RQ23]
				clk_synth_pkg::IDX_FB_DIV_LOW:  b_d.fbl_sh = wr_data; // [RQ11]
				clk_synth_pkg::IDX_FB_DIV_HIGH: b_d.fbh_sh = wr_data[3:0]; // [RQ11]
				clk_synth_pkg::IDX_PHASE_OFFSET:
					b_d.ofs = wr_data & clk_synth_pkg::MASK_PHASE_OFFSET; // [RQ23]
				clk_synth_pkg::IDX_PHASE_RES: b_d.res_sh = wr_data[1:0];
				clk_synth_pkg::IDX_SOFT_RESET: begin
					if (wr_data[clk_synth_pkg::SR_PLL]) begin
						b_d.loop_wk = b_q.loop_sh; // [RQ17]
						b_d.fbl_wk  = b_q.fbl_sh; // [RQ17]
						b_d.fbh_wk  = b_q.fbh_sh; // [RQ17]
						b_d.div_cnt = 12'h000;
					end
					if (wr_data[clk_synth_pkg::SR_PHASE]) begin
						b_d.res_wk = b_q.res_sh; // [RQ18]
					end
				end
				default: begin
					b_d.index = b_q.index + 8'h01;
				end
			endcase
		end else if (rd_adv) begin
			b_d.index = b_q.index + 8'h01;
		end
		// Pump off at once, rearm on second edge [RQ22]
		if (!pump_request) begin
			b_d.armed = 1'b0;
			b_d.edges = 2'h0;
		end else if (!b_q.armed && ref_ev_c) begin
			b_d.edges = b_q.edges + 2'h1;
			if (b_q.edges + 2'h1 == clk_synth_pkg::REARM_SYNC_EDGES) begin
				b_d.armed = 1'b1;
			end
		end
		// Internal divider chain [RQ12]
		if (!(wr_stb && !wr_first
			&& b_q.index == clk_synth_pkg::IDX_SOFT_RESET
			&& wr_data[clk_synth_pkg::SR_PLL])) begin
			b_d.div_cnt = div_wrap ? 12'h000 : b_q.div_cnt + 12'h001;
		end
		// Feedback source and edge [RQ4] [RQ5]
		if (b_q.in_ctl[clk_synth_pkg::IC_FB_SEL]) begin
			b_d.fb_ev = b_q.in_ctl[clk_synth_pkg::IC_FB_POL]
				? (b_q.xfb_p & ~external_feedback_pin)
				: (~b_q.xfb_p & external_feedback_pin);
		end else begin
			b_d.fb_ev = div_wrap;
		end
		// Function output source [RQ6] [RQ20]
		b_d.func = b_q.in_ctl[clk_synth_pkg::IC_FUNC_SEL] ? sync_in
			: (b_d.div_cnt < {9'h000, clk_synth_pkg::FUNC_PULSE_CLOCKS});
		// Shared output [RQ7] [RQ8] [RQ21]
		b_d.lockref = b_q.in_ctl[clk_synth_pkg::IC_REF_EN] ? sync_in
			: (b_q.in_ctl[clk_synth_pkg::IC_LOCK_EN] & pll_lock);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			b_q <= '{index: 8'h00,
				in_ctl: clk_synth_pkg::RST_INPUT_CONTROL,
				loop_sh: clk_synth_pkg::RST_LOOP_CONTROL,
				loop_wk: clk_synth_pkg::RST_LOOP_CONTROL,
				fbl_sh: clk_synth_pkg::RST_FB_DIV_LOW,
				fbl_wk: clk_synth_pkg::RST_FB_DIV_LOW,
				fbh_sh: clk_synth_pkg::RST_FB_DIV_HIGH,
				fbh_wk: clk_synth_pkg::RST_FB_DIV_HIGH,
				ofs: clk_synth_pkg::RST_PHASE_OFFSET,
				res_sh: clk_synth_pkg::RST_PHASE_RES,
				res_wk: clk_synth_pkg::RST_PHASE_RES,
				sync_p: 1'b0, xfb_p: 1'b0, armed: 1'b1, edges: 2'h0,
				div_cnt: 12'h000, func: 1'b0, lockref: 1'b0,
				ref_ev: 1'b0, fb_ev: 1'b0};
		end else begin
			b_q <= b_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign pump_enable = pump_request & b_q.armed; // [RQ22]
	assign ref_edge      = b_q.ref_ev;
	assign feedback_edge = b_q.fb_ev;
	assign func_out      = b_q.func;
	assign lock_ref_out  = b_q.lockref;
	assign pump_current_code          = b_q.loop_wk[2:0]; // [RQ9]
	assign oscillator_postdivide_code = b_q.loop_wk[5:4]; // [RQ10]
	assign feedback_divide        = {b_q.fbh_wk, b_q.fbl_wk}; // [RQ11]
	assign phase_delay_offset     = b_q.ofs[5:0]; // [RQ13]
	assign phase_delay_resolution = b_q.res_wk; // [RQ15]
	assign internal_filter_select = b_q.ofs[clk_synth_pkg::OFS_FILTER]; // [RQ14]

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic soft_pll;
	assign soft_pll = wr_stb && !wr_first
		&& b_q.index == clk_synth_pkg::IDX_SOFT_RESET
		&& wr_data[clk_synth_pkg::SR_PLL];
	logic soft_phase;
	assign soft_phase = wr_stb && !wr_first
		&& b_q.index == clk_synth_pkg::IDX_SOFT_RESET
		&& wr_data[clk_synth_pkg::SR_PHASE];

	sequence pump_drop_s;
		$fell(pump_request);
	endsequence

	chk_pump_off_now: assert property (@(posedge clk) disable iff (rst) // [RQ22]
		pump_drop_s |-> !pump_enable)
		else $error("pump stayed on after request fell");
	chk_pump_source: assert property (@(posedge clk) disable iff (rst) // [RQ1]
		b_q.in_ctl[0] && b_q.armed |-> pump_enable)
		else $error("pump off while always enabled");
	chk_hold_level: assert property (@(posedge clk) disable iff (rst) // [RQ2]
		!b_q.in_ctl[0] && (pump_hold_pin == b_q.in_ctl[1]) |-> !pump_enable)
		else $error("pump on while hold pin inactive");
	chk_ref_edge_sel: assert property (@(posedge clk) disable iff (rst) // [RQ3]
		!b_q.in_ctl[2] && $rose(sync_in) |=> ref_edge)
		else $error("rising reference edge missed");
	chk_shadow_hold: assert property (@(posedge clk) disable iff (rst) // [RQ17]
		!soft_pll |=> $stable(feedback_divide))
		else $error("working divide changed without reset");
	chk_shadow_copy: assert property (@(posedge clk) disable iff (rst) // [RQ17]
		soft_pll |=> feedback_divide == $past({b_q.fbh_sh, b_q.fbl_sh}))
		else $error("divide not loaded on reset");
	sequence func_quiet_s;
		!b_q.in_ctl[clk_synth_pkg::IC_FUNC_SEL] && !soft_pll;
	endsequence
	sequence div_start_s;
		div_wrap ##0 func_quiet_s;
	endsequence
	chk_func_width: assert property (@(posedge clk) disable iff (rst) // [RQ20]
		div_start_s ##1 func_quiet_s [*4] |->
		($past(func_out, 3) && $past(func_out, 2) && $past(func_out)
		&& func_out) ##1 !func_out)
		else $error("recovered sync pulse not four clocks");
	chk_lock_route: assert property (@(posedge clk) disable iff (rst) // [RQ21]
		!b_q.in_ctl[7] && !b_q.in_ctl[6] |=> !lock_ref_out)
		else $error("lock output not disabled");
	chk_ref_route: assert property (@(posedge clk) disable iff (rst) // [RQ8]
		b_q.in_ctl[7] |=> lock_ref_out == $past(sync_in))
		else $error("shared output not following reference");
	chk_fb_internal: assert property (@(posedge clk) disable iff (rst) // [RQ5]
		!b_q.in_ctl[4] |=> feedback_edge == $past(div_wrap))
		else $error("internal feedback edge wrong");
	chk_fb_external: assert property (@(posedge clk) disable iff (rst) // [RQ4]
		b_q.in_ctl[4] && !b_q.in_ctl[3] && $rose(external_feedback_pin)
		|=> feedback_edge)
		else $error("rising feedback edge missed");
	chk_res_hold: assert property (@(posedge clk) disable iff (rst) // [RQ18]
		!soft_phase |=> $stable(phase_delay_resolution))
		else $error("working resolution changed without reset");
	chk_reserved_zero: assert property (@(posedge clk) disable iff (rst) // [RQ23]
		b_q.index == clk_synth_pkg::IDX_FB_DIV_HIGH |-> rd_data[7:4] == 4'h0)
		else $error("reserved bits read nonzero");

endmodule : clock_synth_control_registers

// *** verif/serial_host.sv ***
// Serial bus host model that programs the control bank
`timescale 1ns/1ps
module serial_host (
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_pull
);
	localparam int HALF = 8;
	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	// Data moves only while the serial clock is low
	task automatic put_bit(input logic b, output logic got);
		tick(2);
		sda_pull = ~b;
		tick(HALF);
		scl = 1'b1;
		tick(HALF / 2);
		got = sda_line;
		tick(HALF / 2);
		scl = 1'b0;
	endtask : put_bit
	task automatic start();
		tick(2);
		sda_pull = 1'b0;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_pull = 1'b1;
		tick(HALF);
		scl = 1'b0;
	endtask : start
	task automatic stop();
		tick(2);
		sda_pull = 1'b1;
		tick(HALF);
		scl = 1'b1;
		tick(HALF);
		sda_pull = 1'b0;
		tick(HALF);
	endtask : stop
	task automatic send(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], g);
		end
		put_bit(1'b1, g);
		ack = ~g;
	endtask : send
	task automatic recv(input logic last, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, g);
			b[i] = g;
		end
		put_bit(last, g);
	endtask : recv
	task automatic write_reg(input logic [7:0] dev, input logic [7:0] idx,
		input logic [7:0] data, output logic ack);
		logic a0, a1, a2;
		start();
		send(dev, a0);
		send(idx, a1);
		send(data, a2);
		stop();
		ack = a0 & a1 & a2;
	endtask : write_reg
	task automatic read_reg(input logic [7:0] dev, input logic [7:0] idx,
		output logic [7:0] data, output logic ack);
		logic a0, a1, a2;
		start();
		send(dev, a0);
		send(idx, a1);
		start();
		send(dev | 8'h01, a2);
		recv(1'b1, data);
		stop();
		ack = a0 & a1 & a2;
	endtask : read_reg
endmodule : serial_host

// *** verif/tb_top.sv ***
// Self-checking testbench of the clock synthesizer control bank
`timescale 1ns/1ps
module tb_top;
	localparam logic [5:0] REV = 6'h15;
	logic        clk, rst, scl, sda_in, sda_out, sda_oe, host_pull;
	logic        addr_sel, sync_in, hold_pin, ext_fb, pll_lock;
	logic        pump_enable, ref_edge, fb_edge, func_out, lock_ref_out;
	logic        filt_sel;
	logic [2:0]  icp;
	logic [1:0]  vcod, res;
	logic [11:0] fdiv;
	logic [5:0]  ofs;
	logic [7:0]  dev;
	int          n_errors, n_checks;
	assign sda_in = ~(sda_oe | host_pull);
	clock_synth_control_registers #(.MASK_REVISION(REV)) i_dut (
		.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe),
		.bus_address_select_pin(addr_sel), .sync_in(sync_in),
		.pump_hold_pin(hold_pin), .external_feedback_pin(ext_fb),
		.pll_lock(pll_lock), .pump_enable(pump_enable),
		.ref_edge(ref_edge), .feedback_edge(fb_edge),
		.func_out(func_out), .lock_ref_out(lock_ref_out),
		.pump_current_code(icp), .oscillator_postdivide_code(vcod),
		.feedback_divide(fdiv), .phase_delay_offset(ofs),
		.phase_delay_resolution(res), .internal_filter_select(filt_sel)
	);
	serial_host i_host (.clk(clk), .sda_line(sda_in), .scl(scl),
		.sda_pull(host_pull));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [23:0] got, input logic [23:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check
	task automatic clks(input int n);
		repeat (n) @(negedge clk);
	endtask : clks
	task automatic wr(input logic [7:0] idx, input logic [7:0] data);
		logic ack;
		i_host.write_reg(dev, idx, data, ack);
		check(24'(ack), 24'h1, "write not acknowledged");
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic       ack;
		logic [7:0] d;
		i_host.read_reg(dev, idx, d, ack);
		check({ack, d}, {1'b1, exp}, "read back");
	endtask : rd
	task automatic pulse();
		sync_in = 1'b1;
		clks(4);
		sync_in = 1'b0;
		clks(4);
	endtask : pulse
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] e [6];
		e = '{8'h41, 8'h00, 8'hff, 8'h0f, 8'h00, {REV, 2'b11}};
		check({pump_enable, lock_ref_out, fdiv, res, icp, vcod, sda_out,
			sda_oe}, {2'b10, 12'hfff, 2'h3, 5'h0, 2'b00},
			"reset outputs");
		for (int i = 0; i < 6; i++) begin
			rd(8'(i), e[i]);
		end
		rd(8'h06, 8'h00);
	endtask : t_reset
	task automatic t_address();
		logic ack;
		for (int s = 0; s < 2; s++) begin
			addr_sel = s[0];
			dev = s[0] ? 8'h4e : clk_synth_pkg::BUS_WRITE_ADDR_LOW;
			i_host.write_reg(dev ^ 8'h02, 8'h04, 8'h11, ack);
			check(24'(ack), 24'h0, "foreign address acknowledged");
			rd(8'h04, 8'h00);
		end
	endtask : t_address
	task automatic t_loop();
		logic [7:0] v;
		logic [4:0] prev;
		prev = 5'h0;
		wr(8'h02, 8'h0c);
		wr(8'h03, 8'h00);
		check(24'(fdiv), 24'hfff, "divide before copy");
		for (int i = 0; i < 8; i++) begin
			v = {2'h0, i[1:0], 1'b0, i[2:0]};
			wr(8'h01, v);
			rd(8'h01, v);
			check(24'({icp, vcod}), 24'(prev), "early copy");
			wr(clk_synth_pkg::IDX_SOFT_RESET, 8'h01);
			prev = {i[2:0], i[1:0]};
			check(24'({icp, vcod}), 24'(prev), "codes");
		end
		check(24'(fdiv), 24'h00c, "divide after copy");
	endtask : t_loop
	task automatic t_func();
		int hi, per;
		hi = 0;
		per = 0;
		for (int k = 0; k < 40 && func_out !== 1'b0; k++) begin
			clks(1);
		end
		for (int k = 0; k < 40 && func_out !== 1'b1; k++) begin
			clks(1);
		end
		for (int k = 0; k < 40 && func_out === 1'b1; k++) begin
			hi++;
			clks(1);
		end
		per = hi;
		for (int k = 0; k < 40 && func_out !== 1'b1; k++) begin
			per++;
			clks(1);
		end
		check(24'(hi), 24'd4, "sync pulse width");
		check(24'(per), 24'd20, "sync period");
	endtask : t_func
	task automatic t_res();
		logic [1:0] c [3];
		logic [1:0] prev;
		c = '{2'h0, 2'h1, 2'h3};
		prev = 2'h3;
		for (int i = 0; i < 3; i++) begin
			wr(8'h05, {6'h0, c[i]});
			rd(8'h05, {REV, c[i]});
			check(24'(res), 24'(prev), "early resolution");
			wr(clk_synth_pkg::IDX_SOFT_RESET, 8'h02);
			check(24'(res), 24'(c[i]), "resolution");
			prev = c[i];
		end
		check(24'(fdiv), 24'h00c, "divide kept");
	endtask : t_res
	task automatic t_offset();
		wr(8'h04, 8'h8a);
		check(24'({filt_sel, ofs}), 24'h4a, "internal filter");
		wr(8'h04, 8'h7f);
		check(24'({filt_sel, ofs}), 24'h3f, "external filter");
		rd(8'h04, 8'h3f);
	endtask : t_offset
	task automatic t_lockref();
		for (int m = 0; m < 4; m++) begin
			wr(8'h00, {m[1:0], 6'h01});
			for (int s = 0; s < 4; s++) begin
				sync_in = s[0];
				pll_lock = s[1];
				clks(3);
				check(24'(lock_ref_out), 24'(m[1] ? s[0] : m[0] & s[1]),
					"shared output");
			end
		end
		sync_in = 1'b0;
	endtask : t_lockref
	task automatic t_edges();
		int nr, nf;
		for (int p = 0; p < 2; p++) begin
			wr(8'h00, 8'h51 | {4'h0, p[0], p[0], 2'h0});
			for (int e = 0; e < 2; e++) begin
				nr = 0;
				nf = 0;
				sync_in = ~e[0];
				ext_fb = ~e[0];
				repeat (6) begin
					clks(1);
					nr += int'(ref_edge);
					nf += int'(fb_edge);
				end
				check(24'(nr), 24'(e == p), "reference edge");
				check(24'(nf), 24'(e == p), "feedback edge");
			end
		end
	endtask : t_edges
	task automatic t_funcsel();
		int hi;
		hi = 0;
		wr(8'h00, 8'h61);
		repeat (30) begin
			clks(1);
			hi += int'(func_out);
		end
		check(24'(hi), 24'd0, "input sync idle");
		sync_in = 1'b1;
		clks(4);
		check(24'(func_out), 24'h1, "input sync high");
		sync_in = 1'b0;
		clks(4);
	endtask : t_funcsel
	task automatic t_pump();
		for (int p = 0; p < 2; p++) begin
			hold_pin = ~p[0];
			wr(8'h00, {6'h10, p[0], 1'b0});
			pulse();
			pulse();
			check(24'(pump_enable), 24'h1, "pump armed");
			hold_pin = p[0];
			#1;
			check(24'(pump_enable), 24'h0, "pump off");
			clks(1);
			hold_pin = ~p[0];
			clks(4);
			check(24'(pump_enable), 24'h0, "pump early");
			pulse();
			check(24'(pump_enable), 24'h0, "pump one edge");
			pulse();
			check(24'(pump_enable), 24'h1, "pump back");
		end
		wr(8'h00, 8'h43);
		hold_pin = 1'b1;
		clks(2);
		check(24'(pump_enable), 24'h1, "pump always on");
	endtask : t_pump
	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (80000) @(posedge clk);
		n_errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		final_report();
	end
	initial begin
		rst = 1'b1;
		addr_sel = 1'b0;
		dev = clk_synth_pkg::BUS_WRITE_ADDR_LOW;
		sync_in = 1'b0;
		hold_pin = 1'b0;
		ext_fb = 1'b0;
		pll_lock = 1'b0;
		n_errors = 0;
		n_checks = 0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		clks(2);
		t_reset();
		t_address();
		t_loop();
		t_func();
		t_res();
		t_offset();
		t_lockref();
		t_edges();
		t_funcsel();
		t_pump();
		final_report();
	end
endmodule : tb_top
